// ==== src/prd_consts.svh ====
// Constants for the reference selector and the feedback dividers.
// Assumes one 200 MHz clock; included by the package and by the testbench.
`ifndef PRD_CONSTS_SVH
`define PRD_CONSTS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define PRD_ADDR_W          10
`define PRD_DATA_W          8
`define PRD_A_PLL_CTL       10'h010
`define PRD_A_R_LO          10'h011
`define PRD_A_R_HI          10'h012
`define PRD_A_SWAL          10'h013
`define PRD_A_MAIN_LO       10'h014
`define PRD_A_MAIN_HI       10'h015
`define PRD_A_PRESC         10'h016
`define PRD_A_SYNC          10'h019
`define PRD_A_PIN_SRC       10'h01b
`define PRD_A_REF_CFG       10'h01c
`define PRD_A_STATUS        10'h01f
`define PRD_A_UPDATE        10'h232

// ------------------------------------------------------------
// storage indices of the staged/active registers
// ------------------------------------------------------------
`define PRD_NREG            10
`define PRD_IX_PLL          0
`define PRD_IX_R_LO         1
`define PRD_IX_R_HI         2
`define PRD_IX_SWAL         3
`define PRD_IX_MAIN_LO      4
`define PRD_IX_MAIN_HI      5
`define PRD_IX_PRESC        6
`define PRD_IX_SYNC         7
`define PRD_IX_PIN_SRC      8
`define PRD_IX_REF_CFG      9

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PRD_B_PRESC_MODE    2:0
`define PRD_B_AB_RST        5
`define PRD_B_R_RST         6
`define PRD_B_SHARED_RST    7
`define PRD_B_SYNC_EN       7:6
`define PRD_B_WATCH_SRC     3:0
`define PRD_B_STAT_SRC      7:4
`define PRD_B_DIFF_EN       0
`define PRD_B_PRI_EN        1
`define PRD_B_SEC_EN        2
`define PRD_B_PREF_SEC      3
`define PRD_B_AUTO_SW       4
`define PRD_B_PIN_SEL       5
`define PRD_B_REG_SEL_SEC   6
`define PRD_B_DEGLITCH_DIS  7
`define PRD_B_PLL_PD        1:0
`define PRD_UPDATE_GO       8'h01

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PRD_RST_PLL_CTL     8'h01
`define PRD_RST_OTHER       8'h00

// ------------------------------------------------------------
// pin source codes
// ------------------------------------------------------------
`define PRD_SRC_ONE         4'h1
`define PRD_SRC_SEC_VALID   4'h4
`define PRD_SRC_PRI_VALID   4'h5
`define PRD_SRC_SEC_BAD     4'h6
`define PRD_SRC_PRI_BAD     4'h7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PRD_MCLK_MHZ        200
`define PRD_REF_TIMEOUT_NS  1000
`define PRD_REF_TIMEOUT_CYC ((`PRD_REF_TIMEOUT_NS * `PRD_MCLK_MHZ) / 1000)

`endif

// ==== src/prd_divider.sv ====
// Programmable counter with reload at terminal count.
// Assumes tick and clear are synchronous to the clock; wrap is combinational.
`timescale 1ns/1ps
`default_nettype none

module prd_divider
    import prd_pkg::*;
#(
    parameter int W = 14
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // control
    input  wire logic         clr_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] div_i,
    // result
    output logic              wrap_o
);

    logic [W-1:0] cnt_q;
    logic         last;

    // zero and one both mean divide by one
    assign last   = (div_i <= W'(1)) ? 1'b1 : (cnt_q == W'(div_i - W'(1)));
    assign wrap_o = tick_i & ~clr_i & last;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            cnt_q <= '0;
        end else if (tick_i) begin
            cnt_q <= last ? '0 : W'(cnt_q + W'(1));
        end
    end

endmodule

`default_nettype wire

// ==== src/prd_pkg.sv ====
// Types shared by the reference selector and the feedback dividers.
// Assumes the constants header sits beside it.
`include "prd_consts.svh"

package prd_pkg;

    // prescaler operating mode
    typedef enum logic {
        PRD_PS_FIXED,
        PRD_PS_DUAL
    } prd_ps_mode_e;

    // reference source index: 0 primary, 1 secondary, 2 differential
    typedef logic [1:0] prd_src_t;

    typedef logic [`PRD_DATA_W-1:0] prd_byte_t;

endpackage

// ==== src/prd_top.sv ====
// Reference selection, switchover deglitch and the R / N dividers in front of
// the phase detector. Reference and feedback clocks arrive as sampled levels
// that are synchronous to MCLK_I; register access over a plain strobe port.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module prd_top
    import prd_pkg::*;
#(
    parameter int R_W         = 14,
    parameter int MAIN_W      = 13,
    parameter int SWAL_W      = 6,
    parameter int TIMEOUT_CYC = `PRD_REF_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                   MCLK_I,
    input  wire logic                   RSTN_I,
    // register port
    input  wire logic [`PRD_ADDR_W-1:0] ADDR_I,
    input  wire logic [`PRD_DATA_W-1:0] WDATA_I,
    input  wire logic                   WR_I,
    input  wire logic                   RD_I,
    output logic      [`PRD_DATA_W-1:0] RDATA_O,
    // reference pins
    input  wire logic                   REF_POS_I,
    input  wire logic                   REF_NEG_I,
    input  wire logic                   REF_DIFF_I,
    input  wire logic                   REF_SEL_I,
    input  wire logic                   SYNC_N_I,
    // feedback clock
    input  wire logic                   FB_CLK_I,
    // receiver power-down controls
    output logic                        DIFF_RX_PD_O,
    output logic                        PRI_SE_PD_O,
    output logic                        SEC_SE_PD_O,
    // phase detector inputs
    output logic                        PD_REF_O,
    output logic                        PD_FB_O,
    // monitor pins
    output logic                        REF_WATCH_O,
    output logic                        STATUS_O,
    output logic                        SEL_SEC_O
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic int reg_index(input logic [`PRD_ADDR_W-1:0] a);
        case (a)
            `PRD_A_PLL_CTL: reg_index = `PRD_IX_PLL;
            `PRD_A_R_LO:    reg_index = `PRD_IX_R_LO;
            `PRD_A_R_HI:    reg_index = `PRD_IX_R_HI;
            `PRD_A_SWAL:    reg_index = `PRD_IX_SWAL;
            `PRD_A_MAIN_LO: reg_index = `PRD_IX_MAIN_LO;
            `PRD_A_MAIN_HI: reg_index = `PRD_IX_MAIN_HI;
            `PRD_A_PRESC:   reg_index = `PRD_IX_PRESC;
            `PRD_A_SYNC:    reg_index = `PRD_IX_SYNC;
            `PRD_A_PIN_SRC: reg_index = `PRD_IX_PIN_SRC;
            `PRD_A_REF_CFG: reg_index = `PRD_IX_REF_CFG;
            default:        reg_index = -1;
        endcase
    endfunction

    function automatic prd_byte_t reset_value(input int i);
        reset_value = (i == `PRD_IX_PLL) ? `PRD_RST_PLL_CTL : `PRD_RST_OTHER;
    endfunction

    // pin function from its source code
    function automatic logic pin_source(input logic [3:0] code,
                                        input logic       pri_ok,
                                        input logic       sec_ok);
        case (code)
            `PRD_SRC_ONE:       pin_source = 1'b1;
            `PRD_SRC_SEC_VALID: pin_source = sec_ok;
            `PRD_SRC_PRI_VALID: pin_source = pri_ok;
            `PRD_SRC_SEC_BAD:   pin_source = ~sec_ok;
            `PRD_SRC_PRI_BAD:   pin_source = ~pri_ok;
            default:            pin_source = 1'b0;
        endcase
    endfunction

    // prescaler base value P for a mode code
    function automatic logic [5:0] presc_value(input logic [2:0] m);
        case (m)
            3'h0:    presc_value = 6'h01;
            3'h1:    presc_value = 6'h02;
            3'h2:    presc_value = 6'h03;
            3'h3:    presc_value = 6'h02;
            3'h4:    presc_value = 6'h04;
            3'h5:    presc_value = 6'h08;
            3'h6:    presc_value = 6'h10;
            default: presc_value = 6'h20;
        endcase
    endfunction

    // ------------------------------------------------------------
    // staged and active registers
    // ------------------------------------------------------------
    prd_byte_t stage_q [`PRD_NREG];
    prd_byte_t act_q   [`PRD_NREG];
    int        wr_ix;
    logic      upd_go;

    assign wr_ix  = reg_index(ADDR_I);
    assign upd_go = WR_I && (ADDR_I == `PRD_A_UPDATE) && (WDATA_I == `PRD_UPDATE_GO);

    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < `PRD_NREG; i++) begin
            if (!RSTN_I) begin
                stage_q[i] <= reset_value(i);
            end else if (WR_I && wr_ix == i) begin
                stage_q[i] <= WDATA_I;
            end
        end
    end

    // staged values move to the active set only on update
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < `PRD_NREG; i++) begin
            if (!RSTN_I) begin
                act_q[i] <= reset_value(i);
            end else if (upd_go) begin
                act_q[i] <= stage_q[i];
            end
        end
    end

    // ------------------------------------------------------------
    // decoded active settings
    // ------------------------------------------------------------
    logic [7:0]        ref_cfg;
    logic              pll_pd;
    logic              diff_mode;
    logic              pri_on;
    logic              sec_on;
    logic              dual_mode;
    logic [R_W-1:0]    r_val;
    logic [MAIN_W-1:0] main_val;
    logic [SWAL_W-1:0] swal_val;
    logic [2:0]        ps_code;
    prd_ps_mode_e      ps_mode;
    logic [5:0]        p_val;

    assign ref_cfg   = act_q[`PRD_IX_REF_CFG];
    assign pll_pd    = act_q[`PRD_IX_PLL][`PRD_B_PLL_PD] != 2'b00;
    assign diff_mode = ref_cfg[`PRD_B_DIFF_EN];
    // reference paths stay off until enabled
    assign pri_on    = ~pll_pd & ~diff_mode & ref_cfg[`PRD_B_PRI_EN];
    assign sec_on    = ~pll_pd & ~diff_mode & ref_cfg[`PRD_B_SEC_EN];
    assign dual_mode = pri_on & sec_on;
    assign r_val     = R_W'({act_q[`PRD_IX_R_HI][5:0], act_q[`PRD_IX_R_LO]});
    assign main_val  = MAIN_W'({act_q[`PRD_IX_MAIN_HI][4:0], act_q[`PRD_IX_MAIN_LO]});
    assign ps_code   = act_q[`PRD_IX_PRESC][`PRD_B_PRESC_MODE];
    assign ps_mode   = (ps_code <= 3'h2) ? PRD_PS_FIXED : PRD_PS_DUAL;
    assign p_val     = presc_value(ps_code);
    // fixed-divide mode ignores the swallow count
    assign swal_val  = (ps_mode == PRD_PS_FIXED) ? '0
                     : SWAL_W'(act_q[`PRD_IX_SWAL][5:0]);

    // ------------------------------------------------------------
    // buffer outputs and reference validity
    // ------------------------------------------------------------
    logic [2:0]  lvl;
    logic [2:0]  lvl_prev_q;
    logic [15:0] idle_q [2];
    logic [1:0]  valid;

    assign lvl[0] = REF_POS_I & pri_on;
    assign lvl[1] = REF_NEG_I & sec_on;
    assign lvl[2] = REF_DIFF_I & diff_mode & ~pll_pd;

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            lvl_prev_q <= '0;
        end else begin
            lvl_prev_q <= lvl;
        end
    end

    // a reference is valid while rising edges keep arriving
    always_ff @(posedge MCLK_I) begin
        for (int i = 0; i < 2; i++) begin
            if (!RSTN_I) begin
                idle_q[i] <= 16'(TIMEOUT_CYC);
            end else if (lvl[i] && !lvl_prev_q[i]) begin
                idle_q[i] <= '0;
            end else if (idle_q[i] < 16'(TIMEOUT_CYC)) begin
                idle_q[i] <= idle_q[i] + 16'h0001;
            end
        end
    end

    assign valid[0] = idle_q[0] < 16'(TIMEOUT_CYC);
    assign valid[1] = idle_q[1] < 16'(TIMEOUT_CYC);

    // ------------------------------------------------------------
    // reference selection
    // ------------------------------------------------------------
    prd_src_t sel_d;
    prd_src_t sel_q;
    logic     man_sec;
    logic     pref;

    assign pref    = ref_cfg[`PRD_B_PREF_SEC];
    // manual choice from pin or configuration bit
    assign man_sec = ref_cfg[`PRD_B_PIN_SEL] ? REF_SEL_I : ref_cfg[`PRD_B_REG_SEL_SEC];

    always_comb begin
        sel_d = sel_q;
        if (diff_mode) begin
            sel_d = 2'h2;
        end else if (dual_mode) begin
            if (ref_cfg[`PRD_B_AUTO_SW]) begin
                // always back to the preferred one when it is valid
                if (valid[pref]) begin
                    sel_d = {1'b0, pref};
                end else if (valid[~pref]) begin
                    sel_d = {1'b0, ~pref};
                end
            end else begin
                sel_d = {1'b0, man_sec};
            end
        end else if (sec_on) begin
            sel_d = 2'h1;
        end else begin
            sel_d = 2'h0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            sel_q <= 2'h0;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // switchover deglitch
    // ------------------------------------------------------------
    logic wait_q;
    logic mux_lvl;
    logic mux_prev_q;
    logic ref_tick;

    // after a change the new source must be seen low first; a stuck-high
    // target therefore never releases the gate
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            wait_q <= 1'b0;
        end else if (sel_d != sel_q && !ref_cfg[`PRD_B_DEGLITCH_DIS]) begin
            wait_q <= 1'b1;
        end else if (ref_cfg[`PRD_B_DEGLITCH_DIS] || !lvl[sel_q]) begin
            wait_q <= 1'b0;
        end
    end

    assign mux_lvl  = wait_q ? 1'b0 : lvl[sel_q];
    assign ref_tick = mux_lvl & ~mux_prev_q;

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            mux_prev_q <= 1'b0;
        end else begin
            mux_prev_q <= mux_lvl;
        end
    end

    // ------------------------------------------------------------
    // counter resets
    // ------------------------------------------------------------
    logic sync_rst;
    logic r_clr;
    logic fb_clr;
    logic [7:0] presc_cfg;

    assign presc_cfg = act_q[`PRD_IX_PRESC];
    assign sync_rst  = (act_q[`PRD_IX_SYNC][`PRD_B_SYNC_EN] != 2'b00) & ~SYNC_N_I;
    // control bits hold the counters as long as they stay set
    assign r_clr     = presc_cfg[`PRD_B_R_RST] | presc_cfg[`PRD_B_SHARED_RST]
                     | sync_rst | pll_pd;
    assign fb_clr    = presc_cfg[`PRD_B_AB_RST] | presc_cfg[`PRD_B_SHARED_RST]
                     | sync_rst | pll_pd;

    // ------------------------------------------------------------
    // reference divider
    // ------------------------------------------------------------
    logic r_wrap;

    prd_divider #(
        .W       (R_W)
    ) u_r_div (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .clr_i   (r_clr),
        .tick_i  (ref_tick),
        .div_i   (r_val),
        .wrap_o  (r_wrap)
    );

    // ------------------------------------------------------------
    // feedback divider: prescaler, main and swallow counters
    // ------------------------------------------------------------
    logic              fb_prev_q;
    logic              fb_tick;
    logic [5:0]        ps_div;
    logic              ps_wrap;
    logic              main_wrap;
    logic [SWAL_W-1:0] swal_q;

    assign fb_tick = FB_CLK_I & ~fb_prev_q & ~pll_pd;

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            fb_prev_q <= 1'b0;
        end else begin
            fb_prev_q <= FB_CLK_I;
        end
    end

    // P+1 for the first swallow-count prescaler periods, P after that,
    // so a full main period spans P*main + swallow input edges while swallow is at most main
    assign ps_div = (ps_mode == PRD_PS_DUAL && swal_q < swal_val)
                  ? 6'(p_val + 6'h01) : p_val;

    prd_divider #(
        .W       (6)
    ) u_presc (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .clr_i   (fb_clr),
        .tick_i  (fb_tick),
        .div_i   (ps_div),
        .wrap_o  (ps_wrap)
    );

    // main count of one passes every prescaler period
    prd_divider #(
        .W       (MAIN_W)
    ) u_main (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .clr_i   (fb_clr),
        .tick_i  (ps_wrap),
        .div_i   (main_val),
        .wrap_o  (main_wrap)
    );

    // swallow zero stretches no period at all
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I || fb_clr || main_wrap) begin
            swal_q <= '0;
        end else if (ps_wrap && swal_q < swal_val) begin
            swal_q <= SWAL_W'(swal_q + SWAL_W'(1));
        end
    end

    // ------------------------------------------------------------
    // phase detector inputs
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            PD_REF_O <= 1'b0;
            PD_FB_O  <= 1'b0;
        end else begin
            PD_REF_O <= r_wrap;
            PD_FB_O  <= main_wrap;
        end
    end

    // ------------------------------------------------------------
    // power-down and monitor pins
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            DIFF_RX_PD_O <= 1'b1;
            PRI_SE_PD_O  <= 1'b1;
            SEC_SE_PD_O  <= 1'b1;
        end else begin
            DIFF_RX_PD_O <= pll_pd | ~diff_mode;
            PRI_SE_PD_O  <= ~pri_on;
            SEC_SE_PD_O  <= ~sec_on;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            REF_WATCH_O <= 1'b0;
            STATUS_O    <= 1'b0;
            SEL_SEC_O   <= 1'b0;
        end else begin
            // follows the watch source code; code 7 makes it high while primary is invalid
            REF_WATCH_O <= pin_source(act_q[`PRD_IX_PIN_SRC][`PRD_B_WATCH_SRC],
                                      valid[0], valid[1]);
            STATUS_O    <= pin_source(act_q[`PRD_IX_PIN_SRC][`PRD_B_STAT_SRC],
                                      valid[0], valid[1]);
            SEL_SEC_O   <= sel_q == 2'h1;
        end
    end

    // ------------------------------------------------------------
    // register read-back
    // ------------------------------------------------------------
    int rd_ix;

    assign rd_ix = reg_index(ADDR_I);

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= '0;
        end else if (RD_I) begin
            if (rd_ix >= 0) begin
                RDATA_O <= stage_q[rd_ix];
            end else if (ADDR_I == `PRD_A_STATUS) begin
                RDATA_O <= {4'h0, wait_q, sel_q == 2'h1, valid[1], valid[0]};
            end else begin
                RDATA_O <= '0;
            end
        end else begin
            RDATA_O <= '0;
        end
    end

endmodule

`default_nettype wire

// ==== tb/prd_properties.sv ====
// port checker for prd_top
// assumes bind into prd_top, one clock
`timescale 1ns/1ps
`default_nettype none
module prd_properties (
    // clock, reset, bus
    input wire logic       MCLK_I,
    input wire logic       RSTN_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       FB_CLK_I,
    // outputs watched
    input wire logic       DIFF_RX_PD_O,
    input wire logic       PRI_SE_PD_O,
    input wire logic       SEC_SE_PD_O,
    input wire logic       PD_REF_O,
    input wire logic       PD_FB_O,
    input wire logic       SEL_SEC_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not idle");
    a_diff_se_off: assert property (!DIFF_RX_PD_O |-> PRI_SE_PD_O && SEC_SE_PD_O)
        else $error("buffers on in diff mode");
    a_ref_pulse_one: assert property (PD_REF_O |=> !PD_REF_O)
        else $error("ref pulse too long");
    a_fb_pulse_one: assert property (PD_FB_O |=> !PD_FB_O)
        else $error("fb pulse too long");
    a_fb_edge_cause: assert property (PD_FB_O |-> $past(FB_CLK_I) || $past(FB_CLK_I, 2))
        else $error("fb pulse without edge");
    a_diff_on_write: assert property ($fell(DIFF_RX_PD_O) |-> $past(WR_I) || $past(WR_I, 2))
        else $error("diff on without write");
    a_pri_on_write: assert property ($fell(PRI_SE_PD_O) |-> $past(WR_I) || $past(WR_I, 2))
        else $error("primary on without write");
    a_switch_dual: assert property ($changed(SEL_SEC_O) |-> !PRI_SE_PD_O && !SEC_SE_PD_O)
        else $error("switch outside dual mode");
endmodule
bind prd_top prd_properties u_prop (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .FB_CLK_I(FB_CLK_I), .DIFF_RX_PD_O(DIFF_RX_PD_O),
    .PRI_SE_PD_O(PRI_SE_PD_O), .SEC_SE_PD_O(SEC_SE_PD_O), .PD_REF_O(PD_REF_O),
    .PD_FB_O(PD_FB_O), .SEL_SEC_O(SEL_SEC_O));
`default_nettype wire

// ==== tb/prd_ref_model.sv ====
// reference oscillators and feedback source
// assumes levels sampled on rising clk_i
`timescale 1ns/1ps
`default_nettype none
module prd_ref_model (
    // clock and control
    input  wire logic clk_i,
    input  wire logic run_pri_i,
    // levels
    output logic      ref_pos_o,
    output logic      ref_neg_o,
    output logic      ref_diff_o,
    output logic      fb_clk_o
);
    logic [2:0] cnt_q = 3'h0;
    // plain always: the initialiser above would be a second driver under always_ff
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 3'h1;
    end
    // stopped primary sits low; secondary always toggles
    assign ref_pos_o  = run_pri_i & cnt_q[2];
    assign ref_neg_o  = cnt_q[2];
    assign ref_diff_o = cnt_q[2];
    assign fb_clk_o   = cnt_q[0];
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for prd_top
// assumes header, package, design and model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "prd_consts.svh"
module tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sync_n = 1'b1, run = 1'b1;
    logic [9:0]  addr = 10'h000;
    logic [7:0]  wdat = 8'h00;
    wire logic [7:0] rdat;
    wire logic   rp, rn, rdf, fb, dpd, ppd, spd, pref, pfb, wat, sel, stat;
    int          miscompares = 0, checks_done = 0, n;
    logic [31:0] tbl [3] = '{32'h0103050c, 32'h0403011a, 32'h02010006};
    always #2.5 clk = ~clk;
    prd_ref_model u_ref (.clk_i(clk), .run_pri_i(run), .ref_pos_o(rp), .ref_neg_o(rn),
        .ref_diff_o(rdf), .fb_clk_o(fb));
    prd_top #(.TIMEOUT_CYC(20)) uut (.MCLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdat), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .REF_POS_I(rp),
        .REF_NEG_I(rn), .REF_DIFF_I(rdf), .REF_SEL_I(wat), .SYNC_N_I(sync_n),
        .FB_CLK_I(fb), .DIFF_RX_PD_O(dpd), .PRI_SE_PD_O(ppd), .SEC_SE_PD_O(spd),
        .PD_REF_O(pref), .PD_FB_O(pfb), .REF_WATCH_O(wat), .STATUS_O(stat), .SEL_SEC_O(sel));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_t(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_t(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat, exp);
    endtask
    task automatic ap;
        wr_t(`PRD_A_UPDATE, `PRD_UPDATE_GO);
        repeat (3) @(posedge clk);
        #1;
    endtask
    // cycles between second and third pulse
    task automatic gap(input logic use_fb, output int len);
        int seen;
        seen = 0;
        len = 0;
        for (int t = 0; t < 400 && seen < 3; t++) begin
            @(posedge clk);
            #1;
            if (seen == 2) len++;
            if ((use_fb ? pfb : pref) === 1'b1) seen++;
        end
    endtask
    task automatic quiet(output int c);
        c = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (pfb === 1'b1) c++;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_t(`PRD_A_PLL_CTL, 8'h01);
        rd_t(`PRD_A_REF_CFG, 8'h00);
        rd_t(10'h3ff, 8'h00);
        chk({5'h0, dpd, ppd, spd}, 8'h07);
        wr_t(`PRD_A_R_LO, 8'h03);
        wr_t(`PRD_A_PLL_CTL, 8'h00);
        wr_t(`PRD_A_REF_CFG, 8'h02);
        chk({5'h0, dpd, ppd, spd}, 8'h07);
        ap();
        chk({5'h0, dpd, ppd, spd}, 8'h05);
        gap(1'b0, n);
        chk(n[7:0], 8'h18);
        wr_t(`PRD_A_R_LO, 8'h00);
        ap();
        gap(1'b0, n);
        chk(n[7:0], 8'h08);
        $display("ref divider test end");
        foreach (tbl[i]) begin
            wr_t(`PRD_A_PRESC, tbl[i][31:24]);
            wr_t(`PRD_A_MAIN_LO, tbl[i][23:16]);
            wr_t(`PRD_A_SWAL, tbl[i][15:8]);
            ap();
            gap(1'b1, n);
            chk(n[7:0], tbl[i][7:0]);
        end
        wr_t(`PRD_A_PRESC, 8'h80);
        ap();
        quiet(n);
        chk(n[7:0], 8'h00);
        rd_t(`PRD_A_PRESC, 8'h80);
        wr_t(`PRD_A_PRESC, 8'h04);
        wr_t(`PRD_A_SYNC, 8'h40);
        ap();
        @(posedge clk);
        sync_n <= 1'b0;
        repeat (3) @(posedge clk);
        quiet(n);
        chk(n[7:0], 8'h00);
        @(posedge clk);
        sync_n <= 1'b1;
        $display("feedback test end");
        wr_t(`PRD_A_REF_CFG, 8'h01);
        ap();
        chk({5'h0, dpd, ppd, spd}, 8'h03);
        wr_t(`PRD_A_PIN_SRC, 8'hf7);
        wr_t(`PRD_A_REF_CFG, 8'h26);
        ap();
        @(posedge clk);
        run <= 1'b0;
        repeat (80) @(posedge clk);
        #1;
        chk({5'h0, stat, wat, sel}, 8'h03);
        @(posedge clk);
        run <= 1'b1;
        repeat (80) @(posedge clk);
        #1;
        chk({5'h0, stat, wat, sel}, 8'h00);
        $display("switchover test end");
        end_sim();
    end
endmodule
`default_nettype wire
